//--- vsp_pkg.sv
/*
  Types shared by the video sync processor.
  Assumes nothing beyond the register header.
*/
package vsp_pkg;

  // ------------------------------------------------------------------
  // Synchronised input pins
  // ------------------------------------------------------------------
  typedef struct packed {
    logic vert_flyback_flag;
    logic horiz_flyback_flag;
    logic v_b;
    logic v_a;
    logic h_b;
    logic h_a;
    logic comp;
  } vsp_pins_t;

  // ------------------------------------------------------------------
  // Analyzer sequence
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    VSP_ANA_IDLE = 2'b00,
    VSP_ANA_WAIT = 2'b01,
    VSP_ANA_MEAS = 2'b10
  } vsp_ana_t;

endpackage

//--- vsp_regs.svh
/*
  Register offsets, field positions, reset values and timing figures of the
  video sync processor. Assumes a single 25 MHz clock and an 8-bit register port.
*/
`ifndef VSP_REGS_SVH
`define VSP_REGS_SVH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define VSP_OFF_CONFIG   8'h40
`define VSP_OFF_MUX      8'h41
`define VSP_OFF_COUNTER  8'h42
`define VSP_OFF_POLARITY 8'h43
`define VSP_OFF_LATCHES  8'h44
`define VSP_OFF_HGEN     8'h45
`define VSP_OFF_VGEN     8'h46
`define VSP_OFF_ENABLES  8'h47

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define VSP_RST_CONFIG   8'h00
`define VSP_RST_MUX      8'h20
`define VSP_RST_COUNTER  8'h00
`define VSP_RST_POLARITY 8'h08
`define VSP_RST_LATCHES  8'h00
`define VSP_RST_HGEN     8'h00
`define VSP_RST_VGEN     8'h00
`define VSP_RST_ENABLES  8'hC3

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define VSP_LAT_COMP     7
`define VSP_LAT_HORIZ    6
`define VSP_LAT_VERT     5
`define VSP_LAT_HORIZ_FLYBACK_FLAG     4
`define VSP_LAT_VERT_FLYBACK_FLAG     3
`define VSP_LAT_MAX      2
`define VSP_LAT_MIN      1
`define VSP_LAT_EQ       0

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define VSP_CLK_MHZ      25
`define VSP_TICK_PER_US  4
`define VSP_HPULSE_US    2
`define VSP_HPULSE_TICKS (`VSP_HPULSE_US * `VSP_TICK_PER_US)
`define VSP_VPULSE_LINES 4
`define VSP_VERT_POLARITY_FLAG_DLY_US  4000
`define VSP_SOG_DT_NS    250
`define VSP_SOG_DT_CYC   ((`VSP_SOG_DT_NS * `VSP_CLK_MHZ) / 1000)
`define VSP_BP1_NS       167
`define VSP_BP2_NS       333
`define VSP_BP3_NS       666
`define VSP_NS_CYC(ns)   (((ns) * `VSP_CLK_MHZ + 999) / 1000)

`endif

//--- vsp_sync_source.sv
/* Model of the incoming sync sources feeding the pin inputs.
   Assumes the bench picks which lines pulse and when all are held low. */
`timescale 1ns/1ps
module vsp_sync_source
  import vsp_pkg::*;
(
  input  wire logic      clock_i,
  input  wire vsp_pins_t active_i,
  input  wire logic      force_low_i,
  output vsp_pins_t      pins_o
);
  logic [5:0] phase = 6'h00;
  // Lines idle high; an active line is low 12 of every 40 cycles, so flags see real falls.
  always_ff @(posedge clock_i)
  begin
    phase <= (phase == 6'h27) ? 6'h00 : phase + 6'h01;
  end
  assign pins_o = force_low_i ? '0 : ~(active_i & {7{phase < 6'h0C}});
endmodule

//--- vsp_top.sv
/*
  Video sync processor: input selection, edge latches, polarity detection,
  free-running generator, analyzers and corrector, with an 8-bit register port.
  Assumes sync pins are asynchronous to clock_i and software keeps the
  generator values in their legal ranges.
*/
// Summary of operation
// - Vertical polarity flag reads 1 for negative sync, updates after about 4 ms.
// - Equalization detect status is refreshed by hardware, valid with generator and analyzer off.
// - Input-set select picks set b at 0, set a at 1; resets to 1.
// - Extension disable at 1 suppresses vertical extension by the vertical count.
// - Clamp polarity 0 gives positive clamp; blank polarity 0 gives negative blanking.
// - Five sticky flags set on falling edges of their inputs, cleared by writing zero.
// - Max flag sets at counter top or threshold, min flag at bottom or threshold.
// - Min alone means positive, max alone negative, both composite sync.
// - Equalization latch sets on pulses too close together; software clears it.
// - Generator makes a positive 2 us horizontal pulse, period (value+1)/4 us.
// - Horizontal analyze measures the low time into the horizontal register, then clears.
// - With generator and analyzer off the horizontal output is corrected.
// - Vertical generator counts 11-bit lines, pulse four lines wide.
// - Vertical analyze counts lines during vertical low, returns 11 bits, then clears.
// - Corrector extends vertical output by the vertical count; zero disables vertical extension.
// - Sync outputs enabled at 0, clamp at 0, blanking enabled at 1.
// - Generation select 1 makes free-running sync, 0 analyzer or corrector.
// - Vertical extend enable forces vertical output high while equalization is seen, with extension disable 0, nonzero vertical count and vertical analyze off.
// - Horizontal blank control 0 blanks horizontal output during the vertical pulse.
// - Two read-only bits show the first horizontal and vertical pin levels.
// - Green sync flag sets when composite falls outside the horizontal window.
`timescale 1ns/1ps
`include "vsp_regs.svh"

module vsp_top
  import vsp_pkg::*;
#(
  parameter int VERT_POLARITY_FLAG_CYCLES = `VSP_VERT_POLARITY_FLAG_DLY_US * `VSP_CLK_MHZ
)(
  input  wire logic       clock_i,
  input  wire logic       srst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       composite_sync_in_i,
  input  wire logic       horiz_sync_in_a_i,
  input  wire logic       horiz_sync_in_b_i,
  input  wire logic       vert_sync_in_a_i,
  input  wire logic       vert_sync_in_b_i,
  input  wire logic       horiz_flyback_in_i,
  input  wire logic       vert_flyback_in_i,
  output logic            horiz_sync_out_o,
  output logic            vert_sync_out_o,
  output logic            clamp_o,
  output logic            blank_o
);

  generate
    if (VERT_POLARITY_FLAG_CYCLES < 2 || VERT_POLARITY_FLAG_CYCLES > 1048575)
      $error("VERT_POLARITY_FLAG_CYCLES out of range");
  endgenerate

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  logic [6:0] pin_raw;
  logic [6:0] meta;
  logic [6:0] stab;
  logic [6:0] stab_d;
  vsp_pins_t  pin;
  vsp_pins_t  fall;

  assign pin_raw = {vert_flyback_in_i, horiz_flyback_in_i, vert_sync_in_b_i, vert_sync_in_a_i,
                    horiz_sync_in_b_i, horiz_sync_in_a_i, composite_sync_in_i};

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++)
    begin : g_sync
      always_ff @(posedge clock_i)
      begin
        meta[gi]   <= srst_i ? 1'b0 : pin_raw[gi];
        stab[gi]   <= srst_i ? 1'b0 : meta[gi];
        stab_d[gi] <= srst_i ? 1'b0 : stab[gi];
      end
    end
  endgenerate

  assign pin  = vsp_pins_t'(stab);
  assign fall = vsp_pins_t'(stab_d & ~stab);

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [7:0] cfg, mux, cnt_ctl, pol, sync_edge_latches, hgen, vgen, sync_output_enables;
  logic       vert_polarity_flag, eq_det;
  wire        wr_cfg = wr_i && addr_i == `VSP_OFF_CONFIG;
  wire        wr_lat = wr_i && addr_i == `VSP_OFF_LATCHES;
  wire        wr_pol = wr_i && addr_i == `VSP_OFF_POLARITY;
  wire        horiz_analyze = cfg[7];
  wire        vert_analyze = cfg[6];
  wire        inh_en = cfg[4];
  wire        vext = cfg[3];
  wire [1:0]  bp = mux[7:6];
  wire        fbsel = mux[5];
  wire        comp_sel = mux[4];
  wire [1:0]  hsel_mode = mux[3:2];
  wire        vinv = mux[1];
  wire        lcv_thr = cnt_ctl[6];
  wire [4:0]  cv = cnt_ctl[4:0];
  wire        input_set_select = pol[3];
  wire        extension_disable = pol[2];
  wire        clamp_polarity = pol[1];
  wire        blank_polarity = pol[0];
  wire        sync_output_disable = sync_output_enables[7];
  wire        clamp_output_disable = sync_output_enables[6];
  wire        blank_output_enable = sync_output_enables[5];
  wire        generation_select = sync_output_enables[4];
  wire        vert_extend_enable = sync_output_enables[3];
  wire        horiz_blank_control = sync_output_enables[2];
  wire [10:0] vtotal = {vgen, cfg[2:0]};

  // ------------------------------------------------------------------
  // Input selection and quarter-microsecond tick
  // ------------------------------------------------------------------
  logic [4:0] frac;
  logic       tick;
  wire        h_sel = input_set_select ? pin.h_a : pin.h_b;
  wire        v_sel = input_set_select ? pin.v_a : pin.v_b;
  wire        v_sel_d = input_set_select ? stab_d[3] : stab_d[4];
  wire        h_src = (comp_sel ? pin.comp : h_sel) ^ hsel_mode[0];
  wire        v_src = v_sel ^ vinv;
  wire        h_ana = fbsel ? h_src : pin.horiz_flyback_flag;
  wire        v_ana = fbsel ? v_src : pin.vert_flyback_flag;

  // 25 MHz is not a whole multiple of 4 MHz, so the tick is spread by a fractional step.
  always_ff @(posedge clock_i)
  begin
    frac <= srst_i ? 5'd0 : ((frac >= 5'd21) ? frac - 5'd21 : frac + 5'd4);
    tick <= !srst_i && frac >= 5'd21;
  end

  // ------------------------------------------------------------------
  // Free-running generator
  // ------------------------------------------------------------------
  logic [7:0]  hpos;
  logic [10:0] vline;
  wire         gen = generation_select;
  wire         h_gen = hpos < 8'(`VSP_HPULSE_TICKS);
  wire         v_gen = vline < 11'(`VSP_VPULSE_LINES);
  wire         h_wrap = tick && hpos >= hgen;

  always_ff @(posedge clock_i)
  begin
    if (srst_i || !gen)
    begin
      hpos  <= 8'h00;
      vline <= 11'h000;
    end
    else if (tick)
    begin
      hpos <= h_wrap ? 8'h00 : hpos + 8'h01;
      if (h_wrap)
        vline <= (vline + 11'h001 >= vtotal) ? 11'h000 : vline + 11'h001;
    end
  end

  // ------------------------------------------------------------------
  // Corrector: equalization window, inhibition and vertical extension
  // ------------------------------------------------------------------
  logic [7:0]  eq_win;
  logic [7:0]  ext_cnt;
  logic        h_src_d, v_src_d;
  wire         corr = !gen && !horiz_analyze;
  wire         h_fall = h_src_d && !h_src;
  wire         v_fall = v_src_d && !v_src;
  wire         eq_event = corr && h_fall && eq_win != 8'h00;
  wire [7:0]   win_len = (hgen > 8'(`VSP_HPULSE_TICKS)) ? hgen + 8'h01 - 8'(`VSP_HPULSE_TICKS) : 8'h01;
  wire         h_inh = inh_en && eq_win != 8'h00 && !h_src_d;
  wire         v_allow = !extension_disable && vgen != 8'h00;
  wire         v_corr = v_src || (v_allow && ext_cnt != 8'h00)
                        || (vert_extend_enable && v_allow && !vert_analyze && eq_det);
  wire         h_corr = h_src && !h_inh && (horiz_blank_control || !v_corr);
  wire         h_final = gen ? h_gen : h_corr;
  wire         v_final = gen ? v_gen : v_corr;

  always_ff @(posedge clock_i)
  begin
    h_src_d <= !srst_i && h_src;
    v_src_d <= !srst_i && v_src;
    if (srst_i || !corr)
      eq_win <= 8'h00;
    else if (h_fall && eq_win == 8'h00)
      eq_win <= win_len;
    else if (tick && eq_win != 8'h00)
      eq_win <= eq_win - 8'h01;
    if (srst_i || !v_allow)
      ext_cnt <= 8'h00;
    else if (v_fall)
      ext_cnt <= vgen;
    else if (h_fall && ext_cnt != 8'h00 && !(vext && eq_det))
      ext_cnt <= ext_cnt - 8'h01;
    if (srst_i)
      eq_det <= 1'b0;
    else if (eq_event)
      eq_det <= 1'b1;
    else if (corr && h_fall)
      eq_det <= 1'b0;
  end

  // ------------------------------------------------------------------
  // Polarity counter, vertical polarity and green sync window
  // ------------------------------------------------------------------
  logic [4:0]  ud;
  logic [15:0] hi_len, lo_len;
  logic        pol_cand;
  logic [19:0] pol_cnt;
  logic [2:0]  sog_dt;
  wire  [4:0]  ud_max = lcv_thr ? cv : 5'h1F;
  wire  [4:0]  ud_min = lcv_thr ? cv : 5'h00;
  wire         sog_event = fall.comp && !h_sel && sog_dt == 3'd0;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      ud <= 5'h10;
    else if (tick)
      ud <= h_sel ? ((ud < 5'h1F) ? ud + 5'h01 : ud) : ((ud > 5'h00) ? ud - 5'h01 : ud);
    if (srst_i)
      sog_dt <= 3'd0;
    else if (h_sel)
      sog_dt <= 3'(`VSP_SOG_DT_CYC);
    else if (sog_dt != 3'd0)
      sog_dt <= sog_dt - 3'd1;
  end

  // Each phase keeps its last length until it starts again, so even a steady level resolves.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      hi_len   <= 16'h0000;
      lo_len   <= 16'h0000;
      pol_cand <= 1'b0;
      pol_cnt  <= 20'h00000;
      vert_polarity_flag     <= 1'b0;
    end
    else
    begin
      hi_len <= !v_sel ? hi_len : (!v_sel_d ? 16'h0001 : (hi_len == 16'hFFFF ? hi_len : hi_len + 16'h0001));
      lo_len <= v_sel ? lo_len : (v_sel_d ? 16'h0001 : (lo_len == 16'hFFFF ? lo_len : lo_len + 16'h0001));
      if (v_sel && hi_len > lo_len)
        pol_cand <= 1'b1;
      else if (!v_sel && lo_len > hi_len)
        pol_cand <= 1'b0;
      if (pol_cand == vert_polarity_flag)
        pol_cnt <= 20'h00000;
      else if (pol_cnt == 20'(VERT_POLARITY_FLAG_CYCLES - 1))
      begin
        vert_polarity_flag    <= pol_cand;
        pol_cnt <= 20'h00000;
      end
      else
        pol_cnt <= pol_cnt + 20'h00001;
    end
  end

  // ------------------------------------------------------------------
  // Analyzers
  // ------------------------------------------------------------------
  vsp_ana_t    ha_st, va_st;
  logic [7:0]  h_meas;
  logic [10:0] v_meas;
  logic        ha_src_d, va_src_d;
  wire         ha_done = ha_st == VSP_ANA_MEAS && ha_src_d == 1'b0 && h_ana;
  wire         va_done = va_st == VSP_ANA_MEAS && va_src_d == 1'b0 && v_ana;

  always_ff @(posedge clock_i)
  begin
    ha_src_d <= !srst_i && h_ana;
    va_src_d <= !srst_i && v_ana;
    if (srst_i || !horiz_analyze || gen)
      ha_st <= VSP_ANA_IDLE;
    else
      case (ha_st)
        VSP_ANA_IDLE: ha_st <= VSP_ANA_WAIT;
        VSP_ANA_WAIT: if (ha_src_d && !h_ana) ha_st <= VSP_ANA_MEAS;
        VSP_ANA_MEAS: if (ha_done) ha_st <= VSP_ANA_IDLE;
        default:      ha_st <= VSP_ANA_IDLE;
      endcase
    if (ha_st != VSP_ANA_MEAS)
      h_meas <= 8'h00;
    else if (tick && h_meas != 8'hFF)
      h_meas <= h_meas + 8'h01;
    if (srst_i || !vert_analyze || gen)
      va_st <= VSP_ANA_IDLE;
    else
      case (va_st)
        VSP_ANA_IDLE: va_st <= VSP_ANA_WAIT;
        VSP_ANA_WAIT: if (va_src_d && !v_ana) va_st <= VSP_ANA_MEAS;
        VSP_ANA_MEAS: if (va_done) va_st <= VSP_ANA_IDLE;
        default:      va_st <= VSP_ANA_IDLE;
      endcase
    if (va_st != VSP_ANA_MEAS)
      v_meas <= 11'h000;
    else if (h_fall && v_meas != 11'h7FF)
      v_meas <= v_meas + 11'h001;
  end

  // ------------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------------
  wire [7:0] lat_set = {fall.comp, fall.h_a | fall.h_b, fall.v_a | fall.v_b, fall.horiz_flyback_flag, fall.vert_flyback_flag,
                        ud == ud_max, ud == ud_min, eq_event};
  wire [7:0] pol_rd = {pol[7], 1'b0, vert_polarity_flag, eq_det, pol[3:0]};
  wire [7:0] enr_rd = {sync_output_enables[7:2], stab[1], stab[3]};
  logic [7:0] rd_mux;

  always_comb
  begin
    case (addr_i)
      `VSP_OFF_CONFIG:   rd_mux = {cfg[7:6], 1'b0, cfg[4:0]};
      `VSP_OFF_MUX:      rd_mux = {mux[7:1], 1'b0};
      `VSP_OFF_COUNTER:  rd_mux = cnt_ctl;
      `VSP_OFF_POLARITY: rd_mux = pol_rd;
      `VSP_OFF_LATCHES:  rd_mux = sync_edge_latches;
      `VSP_OFF_HGEN:     rd_mux = hgen;
      `VSP_OFF_VGEN:     rd_mux = vgen;
      `VSP_OFF_ENABLES:  rd_mux = enr_rd;
      default:           rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      cfg <= `VSP_RST_CONFIG;  mux <= `VSP_RST_MUX;   cnt_ctl <= `VSP_RST_COUNTER;
      pol <= `VSP_RST_POLARITY; sync_edge_latches <= `VSP_RST_LATCHES;
      hgen <= `VSP_RST_HGEN;   vgen <= `VSP_RST_VGEN; sync_output_enables <= `VSP_RST_ENABLES;
      rdata_o <= 8'h00;
    end
    else
    begin
      rdata_o <= rd_i ? rd_mux : 8'h00;
      if (wr_cfg)
        cfg <= {wdata_i[7:6], 1'b0, wdata_i[4:0]};
      else if (ha_done || va_done)
        cfg <= {cfg[7] && !ha_done, cfg[6] && !va_done, cfg[5:3], va_done ? v_meas[2:0] : cfg[2:0]};
      if (wr_i && addr_i == `VSP_OFF_MUX)     mux <= {wdata_i[7:1], 1'b0};
      if (wr_i && addr_i == `VSP_OFF_COUNTER) cnt_ctl <= wdata_i;
      if (wr_pol)
        pol[3:0] <= wdata_i[3:0];
      // A flag set in the same cycle as a clearing write stays set.
      pol[7] <= (pol[7] && (!wr_pol || wdata_i[7])) || sog_event;
      sync_edge_latches   <= (sync_edge_latches & (wr_lat ? wdata_i : 8'hFF)) | lat_set;
      if (ha_done)
        hgen <= h_meas;
      else if (wr_i && addr_i == `VSP_OFF_HGEN)
        hgen <= wdata_i;
      if (va_done)
        vgen <= v_meas[10:3];
      else if (wr_i && addr_i == `VSP_OFF_VGEN)
        vgen <= wdata_i;
      if (wr_i && addr_i == `VSP_OFF_ENABLES)
        sync_output_enables <= {wdata_i[7:2], 2'b00};
    end
  end

  // ------------------------------------------------------------------
  // Outputs: sync, clamp and blanking
  // ------------------------------------------------------------------
  logic [4:0] clamp_cnt;
  logic       h_final_d;
  wire        clamp_trig = hsel_mode[1] ? (h_final_d && !h_final) : (!h_final_d && h_final);
  wire  [4:0] bp_len = (bp == 2'd1) ? 5'(`VSP_NS_CYC(`VSP_BP1_NS)) :
                       (bp == 2'd2) ? 5'(`VSP_NS_CYC(`VSP_BP2_NS)) : 5'(`VSP_NS_CYC(`VSP_BP3_NS));
  wire        clamp_act = clamp_cnt != 5'd0 && !clamp_output_disable;
  wire        blank_act = blank_output_enable && (h_final || v_final);

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      h_final_d <= 1'b0;
      clamp_cnt <= 5'd0;
      horiz_sync_out_o <= 1'b0;
      vert_sync_out_o  <= 1'b0;
      clamp_o <= 1'b0;
      blank_o <= 1'b1;
    end
    else
    begin
      h_final_d <= h_final;
      if (clamp_trig && bp != 2'd0)
        clamp_cnt <= bp_len;
      else if (clamp_cnt != 5'd0)
        clamp_cnt <= clamp_cnt - 5'd1;
      horiz_sync_out_o <= !sync_output_disable && h_final;
      vert_sync_out_o  <= !sync_output_disable && v_final;
      clamp_o <= clamp_act ^ clamp_polarity;
      blank_o <= blank_act ^ !blank_polarity;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  logic [7:0] hw_cnt;
  always_ff @(posedge clock_i)
    hw_cnt <= (srst_i || !h_gen || !gen) ? 8'h00 : hw_cnt + 8'h01;

  chk_comp_flag_set: assert property (@(posedge clock_i) disable iff (srst_i)
    fall.comp |=> sync_edge_latches[`VSP_LAT_COMP]) else $error("composite flag not set");
  chk_flag_zero_clear: assert property (@(posedge clock_i) disable iff (srst_i)
    wr_lat && !wdata_i[`VSP_LAT_VERT_FLYBACK_FLAG] && !fall.vert_flyback_flag |=> !sync_edge_latches[`VSP_LAT_VERT_FLYBACK_FLAG])
    else $error("flyback flag not cleared");
  chk_flag_one_keep: assert property (@(posedge clock_i) disable iff (srst_i)
    wr_lat && wdata_i[`VSP_LAT_HORIZ_FLYBACK_FLAG] |=> sync_edge_latches[`VSP_LAT_HORIZ_FLYBACK_FLAG] == $past(sync_edge_latches[`VSP_LAT_HORIZ_FLYBACK_FLAG] || fall.horiz_flyback_flag))
    else $error("flag changed by writing one");
  chk_eq_latch_set: assert property (@(posedge clock_i) disable iff (srst_i)
    eq_event |=> sync_edge_latches[`VSP_LAT_EQ] && eq_det) else $error("equalization not latched");
  chk_hgen_width: assert property (@(posedge clock_i) disable iff (srst_i || !gen)
    $fell(h_gen) && $past(gen, 60) |-> hw_cnt >= 8'd49 && hw_cnt <= 8'd51)
    else $error("generated horizontal width wrong");
  chk_hana_result: assert property (@(posedge clock_i) disable iff (srst_i)
    ha_done && !wr_cfg && !wr_i |=> !horiz_analyze && hgen == $past(h_meas)) else $error("horizontal result lost");
  chk_vert_polarity_flag_hold: assert property (@(posedge clock_i) disable iff (srst_i)
    $changed(vert_polarity_flag) |-> $past(pol_cnt) == 20'(VERT_POLARITY_FLAG_CYCLES - 1)) else $error("polarity changed early");
  chk_sync_disable: assert property (@(posedge clock_i) disable iff (srst_i)
    sync_output_disable |=> !horiz_sync_out_o && !vert_sync_out_o) else $error("sync driven while off");
  chk_blank_idle: assert property (@(posedge clock_i) disable iff (srst_i)
    !blank_output_enable |=> blank_o == !$past(blank_polarity)) else $error("blank not at idle level");

endmodule

//--- vsp_top_bench.sv
/* Self-checking bench for the video sync processor.
   Assumes the register header, package and source model are compiled first. */
`timescale 1ns/1ps
module vsp_top_bench
  import vsp_pkg::*;
;
  logic       clock_i = 1'b0;
  logic       srst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic       force_low = 1'b0;
  logic [7:0] rdata_o;
  logic       hs_o, vs_o, blank_o, cl_o;
  vsp_pins_t  pins, pat;
  vsp_pins_t  active = '0;
  logic [7:0] rst_tab [8] = '{8'h00, 8'h20, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'hC3};
  int         num_errors = 0, compares = 0, cycles = 0, seed = 87, hi, per, k;

  vsp_top #(.VERT_POLARITY_FLAG_CYCLES(20)) dut (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .composite_sync_in_i(pins.comp),
    .horiz_sync_in_a_i(pins.h_a), .horiz_sync_in_b_i(pins.h_b), .vert_sync_in_a_i(pins.v_a),
    .vert_sync_in_b_i(pins.v_b), .horiz_flyback_in_i(pins.horiz_flyback_flag), .vert_flyback_in_i(pins.vert_flyback_flag),
    .horiz_sync_out_o(hs_o), .vert_sync_out_o(vs_o), .clamp_o(cl_o), .blank_o(blank_o));
  vsp_sync_source src (.clock_i(clock_i), .active_i(active), .force_low_i(force_low), .pins_o(pins));

  always #20 clock_i = ~clock_i;
  // The whole run needs about 40000 cycles; a hang is cut off well above that.
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      num_errors++;
      complete_run;
    end
  end

  task automatic complete_run;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
    chk(n, e & m, v & m);
  endtask

  function automatic logic sel(input logic v);
    return v ? vs_o : hs_o;
  endfunction

  // Rise to fall gives the width, rise to next rise the period.
  task automatic measure(input logic v, output int w, output int p);
    w = 0;
    p = 0;
    while (sel(v) !== 1'b0) @(posedge clock_i) #1;
    while (sel(v) !== 1'b1) @(posedge clock_i) #1;
    while (sel(v) === 1'b1)
    begin
      @(posedge clock_i) #1;
      w++;
    end
    p = w;
    while (sel(v) === 1'b0)
    begin
      @(posedge clock_i) #1;
      p++;
    end
  endtask

  function automatic logic [7:0] exp_flags(input vsp_pins_t p);
    // Set a pulses every 40 cycles, well inside the widest equalization window.
    return {p.comp, p.h_a | p.h_b, p.v_a | p.v_b, p.horiz_flyback_flag, p.vert_flyback_flag, 2'h0, p.h_a};
  endfunction

  initial
  begin
    repeat (8) @(posedge clock_i);
    srst_i <= 1'b0;
    chk("blank idle", 16'h0001, {15'h0000, blank_o});
    chk("clamp idle", 16'h0000, {15'h0000, cl_o});
    for (k = 0; k < 8; k++) rc("reset value", 8'h40 + k[7:0], (k == 3) ? 8'hCF : 8'hFF, rst_tab[k]);
    rc("unmapped", 8'h48, 8'hFF, 8'h00);
    force_low <= 1'b1;
    repeat (10) @(posedge clock_i);
    wr(8'h44, 8'h00);
    repeat (300) @(posedge clock_i);
    rc("min flag", 8'h44, 8'h06, 8'h02);
    rc("vert polarity", 8'h43, 8'h20, 8'h00);
    rc("pin levels", 8'h47, 8'h03, 8'h00);
    force_low <= 1'b0;
    repeat (10) @(posedge clock_i);
    wr(8'h44, 8'h00);
    // The high level must outlast the long low before it before the polarity flips.
    repeat (600) @(posedge clock_i);
    rc("max flag", 8'h44, 8'h06, 8'h04);
    rc("vert polarity", 8'h43, 8'h20, 8'h20);
    wr(8'h43, 8'h0B);
    repeat (4) @(posedge clock_i);
    chk("blank inverted", 16'h0000, {15'h0000, blank_o});
    chk("clamp inverted", 16'h0001, {15'h0000, cl_o});
    wr(8'h43, 8'h08);
    wr(8'h45, 8'hFF);
    for (k = 0; k < 5; k++)
    begin
      wr(8'h44, 8'h00);
      pat = (k == 0) ? 7'h7F : 7'($random(seed));
      active <= pat;
      repeat (100) @(posedge clock_i);
      active <= '0;
      repeat (6) @(posedge clock_i);
      rc("edge flags", 8'h44, 8'hF9, exp_flags(pat));
      wr(8'h44, 8'hF7);
      rc("flags kept", 8'h44, 8'hF9, exp_flags(pat) & 8'hF1);
    end
    k = 3 + ($unsigned($random(seed)) % 62);
    wr(8'h45, 8'(4 * k - 1));
    wr(8'h47, 8'h50);
    measure(1'b0, hi, per);
    measure(1'b0, hi, per);
    chk("h width", 16'd50, 16'(hi));
    chk("h period", 16'(25 * k), 16'(per));
    wr(8'h45, 8'h1F);
    wr(8'h46, 8'h05);
    measure(1'b1, hi, per);
    measure(1'b1, hi, per);
    chk("v width", 16'd800, 16'(hi));
    chk("v period", 16'd8000, 16'(per));
    wr(8'h47, 8'hD0);
    repeat (4) @(posedge clock_i);
    hi = 0;
    repeat (700) @(posedge clock_i) #1 hi += (hs_o !== 1'b0 || vs_o !== 1'b0);
    chk("disabled sync", 16'h0000, 16'(hi));
    complete_run;
  end
endmodule
